// *** stt_pkg.sv ***
`default_nettype none
package stt_pkg;

	// Register byte offsets.
	localparam logic [7:0] STT_MODE_OFS = 8'h00;
	localparam logic [7:0] STT_STATUS_OFS = 8'h04;
	localparam logic [7:0] STT_VALUE_ACK_OFS = 8'h08;
	localparam logic [7:0] STT_SNAPSHOT_OFS = 8'h0c;
	localparam logic [7:0] STT_EVT_OFS = 8'h10;
	localparam logic [7:0] STT_EVT_MASK_OFS = 8'h14;

	// Field widths and positions.
	localparam int STT_LIMIT_W = 20;
	localparam int STT_OVF_W = 12;
	localparam int STT_LIMIT_LSB = 0;
	localparam int STT_RUN_EN_BIT = 24;
	localparam int STT_IRQ_EN_BIT = 25;
	localparam int STT_FLAG_BIT = 0;
	localparam int STT_EVT_W = 2;
	localparam int STT_EVT_REACH_BIT = 0;
	localparam int STT_EVT_WRAP_BIT = 1;

	// Reset values.
	localparam logic [19:0] STT_LIMIT_RST = 20'hfffff;
	localparam logic STT_RUN_EN_RST = 1'b0;
	localparam logic STT_IRQ_EN_RST = 1'b0;
	localparam logic [31:0] STT_ZERO_RST = 32'h0000_0000;

	// Tick timing: the counters advance once per this many clock cycles.
	localparam int STT_TICK_DIV = 16;
	localparam int STT_PRESC_W = 4;
	localparam logic [3:0] STT_PRESC_LAST = 4'(STT_TICK_DIV - 1);

	typedef struct packed {
		logic irqEn;
		logic runEn;
		logic [STT_LIMIT_W-1:0] limit;
	} stt_mode_t;

	// Counter word as it appears in the value and snapshot registers.
	typedef struct packed {
		logic [STT_OVF_W-1:0] overflowCount;
		logic [STT_LIMIT_W-1:0] intervalCount;
	} stt_count_t;

endpackage : stt_pkg
`default_nettype wire

// *** stt_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

module stt_timer
	import stt_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Core debug state, synchronous to clk.
	input wire logic dbgHalt,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt.
	output logic irq
);

	stt_mode_t mode_q;
	stt_count_t cnt_q;
	logic [STT_PRESC_W-1:0] presc_q;
	logic flag_q;
	logic [STT_EVT_W-1:0] evt_q;
	logic [STT_EVT_W-1:0] evtMask_q;
	logic [31:0] rdData_q;
	logic readyState_q;
	logic slvErr_q;
	logic irq_q;

	logic tick;
	logic counting;
	logic reach;
	logic ovfWrap;
	logic setupPh;
	logic accessPh;
	logic wrAcc;
	logic valueRdAcc;
	logic mapped;
	logic [STT_OVF_W-1:0] ovf_d;
	logic [31:0] rdData_d;

	assign setupPh = psel & ~penable;
	assign accessPh = psel & penable & readyState_q;
	assign wrAcc = accessPh & pwrite & ~slvErr_q;
	assign valueRdAcc = accessPh & ~pwrite & (paddr == STT_VALUE_ACK_OFS);

	// tick divider
	// The prescaler also freezes in debug so the next tick keeps its phase.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			presc_q <= '0;
		end else if (!dbgHalt) begin
			presc_q <= presc_q + 4'h1;
		end
	end

	assign tick = (presc_q == STT_PRESC_LAST) & ~dbgHalt;

	// enable at zero
	// A nonzero count always runs on until it is back at zero, so the enable bit only matters at zero.
	assign counting = (cnt_q.intervalCount != '0) | mode_q.runEn;
	assign reach = tick & counting & (cnt_q.intervalCount == mode_q.limit);
	assign ovfWrap = reach & (cnt_q.overflowCount == '1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q.intervalCount <= '0;
		end else if (reach) begin
			cnt_q.intervalCount <= '0;
		end else if (tick && counting) begin
			cnt_q.intervalCount <= cnt_q.intervalCount + 20'h1;
		end
	end

	// destructive read
	// The returned count was latched at setup; subtracting it keeps any
	// interval that ended between setup and access.
	always_comb begin
		ovf_d = cnt_q.overflowCount;
		if (valueRdAcc) begin
			ovf_d = ovf_d - rdData_q[31:STT_LIMIT_W];
		end
		if (reach) begin
			ovf_d = ovf_d + 12'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q.overflowCount <= '0;
		end else begin
			cnt_q.overflowCount <= ovf_d;
		end
	end

	// flag set
	// Set beats the read clear, and intervals not yet returned keep it up.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 1'b0;
		end else if (reach) begin
			flag_q <= 1'b1;
		end else if (valueRdAcc) begin
			flag_q <= (ovf_d != '0);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q.limit <= STT_LIMIT_RST;
			mode_q.runEn <= STT_RUN_EN_RST;
			mode_q.irqEn <= STT_IRQ_EN_RST;
		end else if (wrAcc && paddr == STT_MODE_OFS) begin
			mode_q.limit <= pwdata[STT_LIMIT_LSB +: STT_LIMIT_W];
			mode_q.runEn <= pwdata[STT_RUN_EN_BIT];
			mode_q.irqEn <= pwdata[STT_IRQ_EN_BIT];
		end
	end

	// Sticky events, cleared by writing one; a new event wins over the clear.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evt_q <= '0;
		end else begin
			for (int i = 0; i < STT_EVT_W; i++) begin
				if ((i == STT_EVT_REACH_BIT && reach) || (i == STT_EVT_WRAP_BIT && ovfWrap)) begin
					evt_q[i] <= 1'b1;
				end else if (wrAcc && paddr == STT_EVT_OFS && pwdata[i]) begin
					evt_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evtMask_q <= '0;
		end else if (wrAcc && paddr == STT_EVT_MASK_OFS) begin
			evtMask_q <= pwdata[STT_EVT_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (flag_q & mode_q.irqEn) | (|(evt_q & evtMask_q));
		end
	end

	// Read mux, sampled in the setup phase so prdata comes from a flop.
	always_comb begin
		rdData_d = STT_ZERO_RST;
		mapped = 1'b1;
		case (paddr)
			STT_MODE_OFS: begin
				rdData_d[STT_LIMIT_LSB +: STT_LIMIT_W] = mode_q.limit;
				rdData_d[STT_RUN_EN_BIT] = mode_q.runEn;
				rdData_d[STT_IRQ_EN_BIT] = mode_q.irqEn;
			end
			STT_STATUS_OFS: begin
				rdData_d[STT_FLAG_BIT] = flag_q;
			end
			STT_VALUE_ACK_OFS, STT_SNAPSHOT_OFS: begin
				rdData_d = cnt_q;
			end
			STT_EVT_OFS: begin
				rdData_d[STT_EVT_W-1:0] = evt_q;
			end
			STT_EVT_MASK_OFS: begin
				rdData_d[STT_EVT_W-1:0] = evtMask_q;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Zero-wait slave: pready rises in the first access cycle.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_q <= STT_ZERO_RST;
			readyState_q <= 1'b0;
			slvErr_q <= 1'b0;
		end else begin
			readyState_q <= setupPh;
			if (setupPh) begin
				rdData_q <= pwrite ? STT_ZERO_RST : rdData_d;
				slvErr_q <= ~mapped | (pwrite && (paddr == STT_STATUS_OFS ||
					paddr == STT_VALUE_ACK_OFS || paddr == STT_SNAPSHOT_OFS));
			end else begin
				// Clearing outside setup keeps the error flop aligned with pready.
				slvErr_q <= 1'b0;
			end
		end
	end

	assign prdata = rdData_q;
	assign pready = readyState_q;
	assign pslverr = slvErr_q;
	assign irq = irq_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	logic [STT_OVF_W-1:0] retOvf;
	assign retOvf = rdData_q[31:STT_LIMIT_W];

	// Cycles since the last tick, frozen in debug like the divider, so the
	// tick period can be checked against the package constant.
	logic [4:0] tickGap_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tickGap_q <= '0;
		end else if (tick) begin
			tickGap_q <= '0;
		end else if (!dbgHalt) begin
			tickGap_q <= tickGap_q + 5'h1;
		end
	end

	tick_spacing_a:
	assert property (tick |=> !tick [*8])
		else $error("tick came sooner than the divider allows");

	count_wrap_a:
	assert property (reach |=> cnt_q.intervalCount == '0 &&
		cnt_q.overflowCount == $past(cnt_q.overflowCount) + 12'h1 -
		($past(valueRdAcc) ? $past(retOvf) : 12'h0))
		else $error("interval did not wrap or overflow did not advance");

	count_step_a:
	assert property (tick && counting && cnt_q.intervalCount != mode_q.limit
		|=> cnt_q.intervalCount == $past(cnt_q.intervalCount) + 20'h1)
		else $error("interval count did not step by one");

	flag_irq_a:
	assert property (flag_q && mode_q.irqEn |=> irq)
		else $error("enabled flag did not raise interrupt");

	no_irq_a:
	assert property (!mode_q.irqEn && !(|(evt_q & evtMask_q)) |=> !irq)
		else $error("interrupt raised with enable low");

	value_clear_a:
	assert property (valueRdAcc && !reach && cnt_q.overflowCount == retOvf
		|=> !flag_q && cnt_q.overflowCount == '0)
		else $error("value read did not clear overflow and flag");

	snapshot_keep_a:
	assert property (accessPh && !pwrite && paddr == STT_SNAPSHOT_OFS && !reach
		|=> $stable(cnt_q.overflowCount) && $stable(flag_q))
		else $error("snapshot read disturbed the counters");

	stop_at_zero_a:
	assert property (cnt_q.intervalCount == '0 && !mode_q.runEn |=> cnt_q.intervalCount == '0)
		else $error("disabled timer left zero");

	debug_hold_a:
	assert property (dbgHalt && !valueRdAcc
		|=> $stable(cnt_q.intervalCount) && $stable(cnt_q.overflowCount))
		else $error("counters moved in debug state");

	apb_ready_a:
	assert property (setupPh |=> pready ##1 !pready)
		else $error("pready not exactly one cycle after setup");

	tick_period_a:
	assert property (tick |-> tickGap_q == 5'(STT_TICK_DIV - 1))
		else $error("tick period differs from the divider");

	presc_hold_a:
	assert property (dbgHalt |=> $stable(presc_q))
		else $error("prescaler moved in debug state");

	flag_set_a:
	assert property (reach |=> flag_q)
		else $error("reached limit did not set the flag");

	ovf_wrap_a:
	assert property (reach && cnt_q.overflowCount == '1 && !valueRdAcc
		|=> cnt_q.overflowCount == '0)
		else $error("overflow count did not wrap to zero");

	run_start_a:
	assert property (cnt_q.intervalCount != '0 && $past(cnt_q.intervalCount) == '0
		|-> $past(mode_q.runEn))
		else $error("counting started with the enable low");

	limit_keep_a:
	assert property (wrAcc && paddr == STT_MODE_OFS && !tick |=> $stable(cnt_q))
		else $error("mode write disturbed the counters");

	mode_write_a:
	assert property (wrAcc && paddr == STT_MODE_OFS
		|=> mode_q.limit == $past(pwdata[STT_LIMIT_LSB +: STT_LIMIT_W]) &&
		mode_q.runEn == $past(pwdata[STT_RUN_EN_BIT]) &&
		mode_q.irqEn == $past(pwdata[STT_IRQ_EN_BIT]))
		else $error("mode write landed in the wrong bits");

	status_read_a:
	assert property (setupPh && !pwrite && paddr == STT_STATUS_OFS
		|=> prdata[STT_FLAG_BIT] == $past(flag_q) &&
		(prdata & ~(32'h1 << STT_FLAG_BIT)) == '0)
		else $error("status word does not show the flag alone");

	count_word_a:
	assert property (setupPh && !pwrite &&
		(paddr == STT_VALUE_ACK_OFS || paddr == STT_SNAPSHOT_OFS)
		|=> prdata[31:STT_LIMIT_W] == $past(cnt_q.overflowCount) &&
		prdata[STT_LIMIT_W-1:0] == $past(cnt_q.intervalCount))
		else $error("counter word has the wrong layout");

	// Refused transfers must leave every writable register alone.
	refused_write_a:
	assert property (accessPh && pwrite && pslverr |=> $stable(mode_q) && $stable(evtMask_q))
		else $error("refused write changed a register");

	err_ready_a:
	assert property (pslverr |-> pready)
		else $error("error shown outside the ready cycle");

	evt_reach_a:
	assert property (reach |=> evt_q[STT_EVT_REACH_BIT])
		else $error("reach event not latched");

	evt_wrap_a:
	assert property (ovfWrap |=> evt_q[STT_EVT_WRAP_BIT])
		else $error("wrap event not latched");

	evt_irq_a:
	assert property (|(evt_q & evtMask_q) |=> irq)
		else $error("unmasked event did not raise interrupt");

	wrap_cov: cover property (reach ##[1:300] reach);
	read_cov: cover property (valueRdAcc && flag_q);
	stop_cov: cover property (cnt_q.intervalCount != '0 && !mode_q.runEn ##[1:300]
		cnt_q.intervalCount == '0);
	debug_cov: cover property (dbgHalt && cnt_q.intervalCount != '0);
	evt_cov: cover property (|(evt_q & evtMask_q) ##1 irq);

endmodule : stt_timer

`default_nettype wire

// *** stt_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
	import stt_pkg::*;
	localparam logic [31:0] RUN = 32'h1 << STT_RUN_EN_BIT;
	localparam logic [31:0] IEN = 32'h1 << STT_IRQ_EN_BIT;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic dbgHalt = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] rdat;
	logic err;
	stt_count_t a;
	stt_count_t b;
	int mismatches = 0;
	int checkCount = 0;
	int cyc = 0;
	stt_timer dut (.clk(clk), .rst_b(rst_b), .dbgHalt(dbgHalt), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	always #25 clk = ~clk;
	task automatic finalReport;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finalReport
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			finalReport();
		end
	end
	task automatic chk(input logic ok, input string m);
		checkCount++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// One idle cycle first so a release and a new setup never share an edge.
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] ad);
		apb(1'b0, ad, 32'h0000_0000);
	endtask : rd
	task automatic doReset;
		rst_b <= 1'b0;
		wt(3);
		rst_b <= 1'b1;
	endtask : doReset
	task automatic resetChecks;
		rd(STT_MODE_OFS);
		chk(rdat === 32'h000f_ffff, "mode reset");
		rd(STT_STATUS_OFS);
		chk(rdat === 32'h0000_0000, "status reset");
		rd(STT_SNAPSHOT_OFS);
		chk(rdat === 32'h0000_0000, "snapshot reset");
		rd(STT_VALUE_ACK_OFS);
		chk(rdat === 32'h0000_0000, "value reset");
		apb(1'b1, STT_STATUS_OFS, 32'h0000_0001);
		chk(err === 1'b1, "ro write accepted");
		apb(1'b1, 8'h18, 32'h0000_0001);
		chk(err === 1'b1, "unmapped accepted");
	endtask : resetChecks
	task automatic limitWrite;
		apb(1'b1, STT_MODE_OFS, RUN | 32'h000f_ffff);
		wt(100);
		rd(STT_SNAPSHOT_OFS);
		a = rdat;
		apb(1'b1, STT_MODE_OFS, RUN | 32'h000f_fff0);
		rd(STT_SNAPSHOT_OFS);
		b = rdat;
		chk(a.intervalCount > 0 && b.intervalCount >= a.intervalCount, "restart");
		rd(STT_MODE_OFS);
		chk(rdat === (RUN | 32'h000f_fff0), "mode readback");
	endtask : limitWrite
	// Limit 3 gives 64-clock intervals; reads finish before a third wrap.
	task automatic irqFlow;
		apb(1'b1, STT_MODE_OFS, IEN | RUN | 32'h0000_0003);
		wt(135);
		rd(STT_SNAPSHOT_OFS);
		chk(rdat[31:20] === 12'h002, "two intervals");
		rd(STT_STATUS_OFS);
		chk(rdat === 32'h0000_0001 && irq === 1'b1, "flag or irq");
		rd(STT_SNAPSHOT_OFS);
		chk(rdat[31:20] === 12'h002, "snapshot cleared");
		rd(STT_VALUE_ACK_OFS);
		chk(rdat[31:20] === 12'h002 && rdat[19:0] < 4, "value word");
		rd(STT_SNAPSHOT_OFS);
		chk(rdat[31:20] === 12'h000 && irq === 1'b0, "ack");
		rd(STT_STATUS_OFS);
		chk(rdat === 32'h0000_0000, "flag kept");
	endtask : irqFlow
	task automatic noIrq;
		apb(1'b1, STT_MODE_OFS, RUN | 32'h0000_0003);
		wt(80);
		rd(STT_STATUS_OFS);
		chk(rdat === 32'h0000_0001 && irq === 1'b0, "masked irq");
		rd(STT_VALUE_ACK_OFS);
	endtask : noIrq
	task automatic stopRun;
		apb(1'b1, STT_MODE_OFS, 32'h0000_0003);
		wt(80);
		rd(STT_SNAPSHOT_OFS);
		a = rdat;
		wt(64);
		rd(STT_SNAPSHOT_OFS);
		chk(a.intervalCount === 20'h0 && rdat === a, "not stopped");
		apb(1'b1, STT_MODE_OFS, RUN | 32'h0000_0003);
		wt(40);
		rd(STT_SNAPSHOT_OFS);
		chk(rdat[19:0] >= 20'h2 && rdat[19:0] <= 20'h3, "no restart");
	endtask : stopRun
	task automatic haltRun;
		apb(1'b1, STT_MODE_OFS, RUN | 32'h0000_00ff);
		wt(40);
		dbgHalt <= 1'b1;
		wt(2);
		rd(STT_SNAPSHOT_OFS);
		a = rdat;
		wt(64);
		rd(STT_SNAPSHOT_OFS);
		chk(a.intervalCount > 20'h0 && rdat === a, "debug halt");
		dbgHalt <= 1'b0;
		wt(40);
		rd(STT_SNAPSHOT_OFS);
		b = rdat;
		chk(b.intervalCount > a.intervalCount, "no resume");
	endtask : haltRun
	// Limit 0 wraps every tick, so the overflow count tracks ticks directly.
	task automatic wrapOvf;
		apb(1'b1, STT_MODE_OFS, 32'h0000_00ff);
		wt(4200);
		apb(1'b1, STT_MODE_OFS, RUN);
		rd(STT_VALUE_ACK_OFS);
		wt(320);
		rd(STT_SNAPSHOT_OFS);
		a = rdat;
		chk(a.overflowCount >= 19 && a.overflowCount <= 21, "tick rate");
		wt(65536);
		rd(STT_SNAPSHOT_OFS);
		b = rdat;
		chk(b.overflowCount - a.overflowCount <= 1, "no wrap");
		rd(STT_EVT_OFS);
		chk(rdat === 32'h0000_0003, "events");
		apb(1'b1, STT_EVT_MASK_OFS, 32'h0000_0002);
		rd(STT_EVT_MASK_OFS);
		chk(rdat === 32'h0000_0002 && irq === 1'b1, "event irq");
		apb(1'b1, STT_EVT_OFS, 32'h0000_0002);
		rd(STT_EVT_OFS);
		chk(rdat[1] === 1'b0 && irq === 1'b0, "event clear");
	endtask : wrapOvf
	initial begin
		doReset();
		resetChecks();
		limitWrite();
		doReset();
		irqFlow();
		noIrq();
		stopRun();
		haltRun();
		wrapOvf();
		finalReport();
	end
endmodule : tb
`default_nettype wire
